// ---- include/lvdsrx_pkg.sv ----
`default_nettype none
package lvdsrx_pkg;
    localparam int          NUM_PHASES   = 8;
    localparam int          TRAIN_REPS   = 256;
    localparam int          FIFO_DEPTH   = 6;
    localparam int          FIFO_PRIME   = 3;
    localparam int          MAX_WORD     = 10;
    localparam int          MAX_ROLL     = 11;
    localparam int          CLK_MHZ      = 250;
    localparam int          PAR_SETTLE   = 2;

    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_CFG     = 4'h4;
    localparam logic [3:0]  ADDR_STATUS  = 4'h8;
    localparam logic [3:0]  ADDR_DATA    = 4'hC;

    localparam int          CTRL_FREEZE  = 0;
    localparam int          CTRL_PRST    = 1;
    localparam int          CTRL_FRST    = 2;
    localparam int          CTRL_SLIP    = 3;

    localparam int          CFG_MODE_LSB = 0;
    localparam int          CFG_EDGE     = 3;
    localparam int          CFG_FACT_LSB = 4;
    localparam int          CFG_ROLL_LSB = 8;

    localparam logic [3:0]  FACTOR_RST   = 4'hA;
    localparam logic [3:0]  ROLL_RST     = 4'hA;
    localparam logic [2:0]  PHASE_RST    = 3'h0;

    typedef enum logic [2:0] {
        LVDSRX_MODE_PICK   = 3'b000,
        LVDSRX_MODE_TRACK  = 3'b001,
        LVDSRX_MODE_STATIC = 3'b010,
        LVDSRX_MODE_DDR    = 3'b011,
        LVDSRX_MODE_SDR    = 3'b100
    } lvdsrx_mode_e;
endpackage : lvdsrx_pkg
`default_nettype wire

// ---- design/lvdsrx_top.sv ----
// Overview of operation
// RULE_01 - Eight phase copies of the serial clock exist; picker selects one for sampling.
// RULE_02 - Phases are 45 degrees apart, so sampling error stays within 1/8 UI.
// RULE_03 - Chosen phase writes the FIFO; tracking mode clocks the deserializer directly.
// RULE_04 - Far end sends 256 repetitions of a pattern with a transition.
// RULE_05 - Freeze input holds the selected phase; release resumes adjustment.
// RULE_06 - Once locked, any phase step drops lock, including two same-direction steps.
// RULE_07 - Picker reset clears phase logic; link must retrain afterwards.
// RULE_08 - Crossing FIFO is one bit wide, six entries deep, into fast clock domain.
// RULE_09 - FIFO absorbs phase offset only, never frequency difference.
// RULE_10 - FIFO resets itself when the picker locks for the first time.
// RULE_11 - A FIFO reset request from core clears the FIFO.
// RULE_12 - Core should reset the FIFO on lock loss plus corrupt data.
// RULE_13 - Each slip rising edge inserts exactly one bit of latency.
// RULE_14 - Slip request stays high and low at least one parallel clock each.
// RULE_15 - Slip is edge sensitive; holding it high gives a single slip.
// RULE_16 - Realigned words appear two parallel cycles after the slip edge.
// RULE_17 - Rollover point is 1 to 11 bits; slip count wraps there.
// RULE_18 - Integrator sets rollover at or above the deserialization factor.
// RULE_19 - Wrap flag is high for exactly one parallel cycle at rollover; the code holds it for two if the rollover slip falls on a word's last bit.
// RULE_20 - Deserializer loads words of factor 4, 6, 7, 8 or 10 bits.
// RULE_21 - In bypass modes the picker and aligner are unused.
// RULE_22 - Bypass: double rate captures two bits per cycle; single rate passes one.
// RULE_23 - In picker mode the fast clock reads the FIFO and runs aligner and deserializer.
// RULE_24 - Tracking mode forwards a parallel clock divided by the factor.
// RULE_25 - Static mode samples on rising or falling edge by a static option.
// RULE_26 - Lock status asserts after training and deasserts on any lock loss.
`timescale 1ns/1ns
`default_nettype none
module lvdsrx_top (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic [7:0]                   ser_phase_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [3:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    output logic [lvdsrx_pkg::MAX_WORD-1:0]   rx_word_o,
    output logic                              rx_word_stb_o,
    output logic                              par_clk_o,
    output logic                              lock_o,
    output logic                              wrap_o
);
    import lvdsrx_pkg::*;

    // Pin synchronisers; stage one feeds only stage two.
    logic [7:0]  meta_q;
    logic [7:0]  samp_q;
    logic        last_samp_q;

    // Register file.
    logic        freeze_q;
    logic        slip_req_q;
    logic        prst_q;
    logic        frst_q;
    logic [2:0]  mode_q;
    logic        edge_fall_q;
    logic [3:0]  factor_q;
    logic [3:0]  roll_q;
    logic [31:0] rdata_d;
    logic [31:0] wb_dat_q;
    logic        wb_ack_q;

    // Phase picker.
    logic [2:0]  phase_q;
    logic [8:0]  train_q;
    logic        lock_q;
    logic        first_done_q;

    // Crossing FIFO.
    logic        fifo_mem_q [FIFO_DEPTH];
    logic [2:0]  wr_ptr_q;
    logic [2:0]  rd_ptr_q;
    logic [2:0]  fifo_cnt_q;

    // Aligner and deserializer.
    logic [MAX_ROLL-1:0] dly_q;
    logic [3:0]  slip_cnt_q;
    logic        slip_prev_q;
    logic        wrap_pend_q;
    logic        wrap_q;
    logic [3:0]  bit_cnt_q;
    logic [MAX_WORD-1:0] sh_q;
    logic [MAX_WORD-1:0] word_q;
    logic        stb_q;
    logic        par_clk_q;

    assign wb_dat_o      = wb_dat_q;
    assign wb_ack_o      = wb_ack_q;
    assign rx_word_o     = word_q;
    assign rx_word_stb_o = stb_q;
    assign par_clk_o     = par_clk_q;
    assign lock_o        = lock_q;
    assign wrap_o        = wrap_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q      <= 8'h00;
            samp_q      <= 8'h00;
            last_samp_q <= 1'b0;
        end else begin
            meta_q      <= ser_phase_i;
            samp_q      <= meta_q;
            last_samp_q <= samp_q[7];
        end
    end

    // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero.
    wire wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_q;
    wire wb_wr    = wb_req && wb_we_i;
    wire wr_ctrl  = wb_wr && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0];
    wire wr_cfg0  = wb_wr && (wb_adr_i == ADDR_CFG) && wb_sel_i[0];
    wire wr_cfg1  = wb_wr && (wb_adr_i == ADDR_CFG) && wb_sel_i[1];

    always_comb begin
        case (wb_adr_i)
            ADDR_CTRL:   rdata_d = {28'h000_0000, slip_req_q, 2'b00, freeze_q};
            ADDR_CFG:    rdata_d = {20'h0_0000, roll_q, factor_q, edge_fall_q, mode_q};
            ADDR_STATUS: rdata_d = {20'h0_0000, slip_cnt_q, wrap_pend_q, 3'b000, phase_q, lock_q};
            ADDR_DATA:   rdata_d = {22'h00_0000, word_q};
            default:     rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= wb_req;
            wb_dat_q <= wb_req ? rdata_d : 32'h0000_0000;
        end
    end

    // Reset requests are self-clearing strobes so software never has to clear them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freeze_q    <= 1'b0;
            slip_req_q  <= 1'b0;
            prst_q      <= 1'b0;
            frst_q      <= 1'b0;
            mode_q      <= LVDSRX_MODE_PICK;
            edge_fall_q <= 1'b0;
            factor_q    <= FACTOR_RST;
            roll_q      <= ROLL_RST;
        end else begin
            prst_q <= wr_ctrl && wb_dat_i[CTRL_PRST];  // [RULE_07]
            frst_q <= wr_ctrl && wb_dat_i[CTRL_FRST];  // [RULE_11]
            if (wr_ctrl) begin
                freeze_q   <= wb_dat_i[CTRL_FREEZE];
                slip_req_q <= wb_dat_i[CTRL_SLIP];
            end
            if (wr_cfg0) begin
                mode_q      <= wb_dat_i[CFG_MODE_LSB +: 3];
                edge_fall_q <= wb_dat_i[CFG_EDGE];      // [RULE_25]
                factor_q    <= wb_dat_i[CFG_FACT_LSB +: 4];
            end
            if (wr_cfg1) begin
                roll_q <= wb_dat_i[CFG_ROLL_LSB +: 4];   // [RULE_17]
            end
        end
    end

    // Phase picker. A transition between two neighbouring phase samples marks the data
    // edge; the ideal sample sits half a UI (four phases) past it.
    wire [7:0] trans = samp_q ^ {samp_q[6:0], last_samp_q};

    function automatic logic [2:0] lvdsrx_first(input logic [7:0] v);
        lvdsrx_first = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                lvdsrx_first = 3'(i);
            end
        end
    endfunction : lvdsrx_first

    wire       seen_edge = |trans;
    wire [2:0] target    = lvdsrx_first(trans) + 3'd4;       // [RULE_01] [RULE_02]
    wire [2:0] fwd_dist  = target - phase_q;
    wire       pick_on   = (mode_q == LVDSRX_MODE_PICK) || (mode_q == LVDSRX_MODE_TRACK);  // [RULE_21]
    wire       step      = pick_on && seen_edge && !freeze_q && (target != phase_q);       // [RULE_05]
    wire [2:0] phase_d   = (fwd_dist < 3'd4) ? phase_q + 3'd1 : phase_q - 3'd1;
    wire       lock_set  = !lock_q && pick_on && (train_q == 9'(TRAIN_REPS - 1)) && seen_edge && !step;
    wire       first_lock = lock_set && !first_done_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || prst_q) begin                              // [RULE_07]
            phase_q      <= PHASE_RST;
            train_q      <= 9'h000;
            lock_q       <= 1'b0;
            first_done_q <= 1'b0;
        end else begin
            if (step) begin
                phase_q <= phase_d;                             // [RULE_02]
                train_q <= 9'h000;
                lock_q  <= 1'b0;                                // [RULE_06] [RULE_26]
            end else if (lock_set) begin
                lock_q  <= 1'b1;                                // [RULE_26]
            end else if (seen_edge && !lock_q && pick_on) begin
                train_q <= train_q + 9'h001;
            end
            if (first_lock) begin
                first_done_q <= 1'b1;
            end
        end
    end

    wire chosen_bit = samp_q[phase_q];                          // [RULE_01]
    wire static_bit = edge_fall_q ? samp_q[4] : samp_q[0];      // [RULE_25]

    // Crossing FIFO. Write and read run at one rate, so the fill stays at the prime level:
    // it only soaks up phase offset and would slip under a frequency difference.
    wire fifo_rst = rst_i || prst_q || frst_q || first_lock;    // [RULE_10] [RULE_11]
    wire fifo_rd  = fifo_cnt_q >= 3'(FIFO_PRIME);               // [RULE_09]
    wire fifo_out = fifo_mem_q[rd_ptr_q];                       // [RULE_23]

    function automatic logic [2:0] lvdsrx_inc(input logic [2:0] p);
        lvdsrx_inc = (p == 3'(FIFO_DEPTH - 1)) ? 3'd0 : p + 3'd1;
    endfunction : lvdsrx_inc

    always_ff @(posedge clk_i) begin
        if (fifo_rst) begin
            wr_ptr_q   <= 3'd0;
            rd_ptr_q   <= 3'd0;
            fifo_cnt_q <= 3'd0;
        end else begin
            fifo_mem_q[wr_ptr_q] <= chosen_bit;                 // [RULE_03] [RULE_08]
            wr_ptr_q <= lvdsrx_inc(wr_ptr_q);
            if (fifo_rd) begin
                rd_ptr_q <= lvdsrx_inc(rd_ptr_q);
            end else begin
                fifo_cnt_q <= fifo_cnt_q + 3'd1;
            end
        end
    end

    // Aligner. Each slip edge in picker or tracking mode moves the tap one bit deeper; the rollover slip returns it to the undelayed bit.
    wire ser_bit = (mode_q == LVDSRX_MODE_TRACK)  ? chosen_bit :     // [RULE_03]
                   (mode_q == LVDSRX_MODE_STATIC) ? static_bit : fifo_out;
    wire slip_rise = slip_req_q && !slip_prev_q && pick_on;          // [RULE_15]
    wire [3:0] slip_next = slip_cnt_q + 4'd1;
    wire slip_wrap = slip_next >= roll_q;                            // [RULE_17]
    wire aligned_bit = (slip_cnt_q == 4'd0) ? ser_bit : dly_q[slip_cnt_q - 4'd1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q       <= '0;
            slip_cnt_q  <= 4'd0;
            slip_prev_q <= 1'b0;
        end else begin
            dly_q       <= {dly_q[MAX_ROLL-2:0], ser_bit};
            slip_prev_q <= slip_req_q;
            if (slip_rise) begin
                slip_cnt_q <= slip_wrap ? 4'd0 : slip_next;          // [RULE_13]
            end
        end
    end

    // Deserializer, MSB first. The forwarded parallel clock is its own register and rises one cycle after the word strobe.
    wire ddr_mode = mode_q == LVDSRX_MODE_DDR;
    wire sdr_mode = mode_q == LVDSRX_MODE_SDR;
    wire last_bit = bit_cnt_q >= factor_q - 4'd1;
    wire [MAX_WORD-1:0] full_word = {sh_q[MAX_WORD-2:0], aligned_bit};
    wire [MAX_WORD-1:0] word_mask = 10'h3FF >> (4'd10 - factor_q);   // [RULE_20]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_q   <= 4'd0;
            sh_q        <= '0;
            word_q      <= '0;
            stb_q       <= 1'b0;
            par_clk_q   <= 1'b0;
            wrap_pend_q <= 1'b0;
            wrap_q      <= 1'b0;
        end else if (ddr_mode) begin
            word_q    <= {8'h00, samp_q[0], samp_q[4]};            // [RULE_22]
            stb_q     <= 1'b1;
            par_clk_q <= !par_clk_q;
            wrap_q    <= 1'b0;
        end else if (sdr_mode) begin
            word_q    <= {9'h000, samp_q[0]};                       // [RULE_22]
            stb_q     <= 1'b1;
            par_clk_q <= !par_clk_q;
            wrap_q    <= 1'b0;
        end else begin
            sh_q      <= full_word;                                 // [RULE_20]
            bit_cnt_q <= last_bit ? 4'd0 : bit_cnt_q + 4'd1;
            stb_q     <= last_bit;
            par_clk_q <= bit_cnt_q < (factor_q >> 1);                // [RULE_24]
            if (slip_rise && slip_wrap) begin
                wrap_pend_q <= 1'b1;
            end else if (last_bit) begin
                wrap_pend_q <= 1'b0;
            end
            if (last_bit) begin
                word_q <= full_word & word_mask;                    // [RULE_16] [RULE_23]
                wrap_q <= wrap_pend_q || (slip_rise && slip_wrap);  // [RULE_19]
            end
        end
    end

    property p_phase_adjacent;
        @(posedge clk_i) disable iff (rst_i) $changed(phase_q) && !$past(prst_q) |->
            (phase_q == $past(phase_q) + 3'd1) || (phase_q == $past(phase_q) - 3'd1);
    endproperty
    a_phase_adjacent: assert property (p_phase_adjacent) else $error("phase moved by more than one step"); // [RULE_02]
    property p_lock_trained;
        @(posedge clk_i) disable iff (rst_i) $rose(lock_q) |-> $past(train_q) == 9'(TRAIN_REPS - 1);
    endproperty
    a_lock_trained: assert property (p_lock_trained) else $error("lock rose before training ended"); // [RULE_26]
    property p_slip_wrap;
        @(posedge clk_i) disable iff (rst_i) slip_rise && slip_wrap |=> slip_cnt_q == 4'd0;
    endproperty
    a_slip_wrap: assert property (p_slip_wrap) else $error("slip count did not wrap"); // [RULE_17]
    // Bypass modes must leave the aligner untouched even when software toggles the slip bit.
    property p_bypass_idle;
        @(posedge clk_i) disable iff (rst_i) (ddr_mode || sdr_mode) |=> $stable(slip_cnt_q);
    endproperty
    a_bypass_idle: assert property (p_bypass_idle) else $error("aligner moved in bypass"); // [RULE_21]
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_ack_q |=> !wb_ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus acknowledge longer than one cycle");
    property p_freeze_hold;
        @(posedge clk_i) disable iff (rst_i) freeze_q && !prst_q |=> $stable(phase_q);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("phase moved while frozen"); // [RULE_05]
    property p_lock_drop;
        @(posedge clk_i) disable iff (rst_i) lock_q && step |=> !lock_q && train_q == 9'h000;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock held over a phase step"); // [RULE_06]
    property p_picker_reset;
        @(posedge clk_i) disable iff (rst_i) prst_q |=> !lock_q && phase_q == PHASE_RST && fifo_cnt_q == 3'd0;
    endproperty
    a_picker_reset: assert property (p_picker_reset) else $error("picker reset ignored"); // [RULE_07]
    property p_fifo_depth;
        @(posedge clk_i) disable iff (rst_i) fifo_cnt_q <= 3'(FIFO_PRIME) && wr_ptr_q < 3'(FIFO_DEPTH);
    endproperty
    a_fifo_depth: assert property (p_fifo_depth) else $error("fifo fill or pointer out of range"); // [RULE_08]
    property p_first_lock_flush;
        @(posedge clk_i) disable iff (rst_i) first_lock |=> fifo_cnt_q == 3'd0 ##1 fifo_cnt_q == 3'd1;
    endproperty
    a_first_lock_flush: assert property (p_first_lock_flush) else $error("fifo not flushed at first lock"); // [RULE_10]
    property p_fifo_reset;
        @(posedge clk_i) disable iff (rst_i) frst_q |=> fifo_cnt_q == 3'd0;
    endproperty
    a_fifo_reset: assert property (p_fifo_reset) else $error("fifo reset ignored"); // [RULE_11]
    property p_slip_once;
        @(posedge clk_i) disable iff (rst_i) slip_req_q && slip_prev_q |=> $stable(slip_cnt_q);
    endproperty
    a_slip_once: assert property (p_slip_once) else $error("held slip request slipped again"); // [RULE_15]
    property p_slip_step;
        @(posedge clk_i) disable iff (rst_i) slip_rise && !slip_wrap |=> slip_cnt_q == $past(slip_cnt_q) + 4'd1;
    endproperty
    a_slip_step: assert property (p_slip_step) else $error("slip did not add one bit"); // [RULE_13]
    property p_wrap_single;
        @(posedge clk_i) disable iff (rst_i) wrap_q && stb_q && !ddr_mode && !sdr_mode |-> $past(wrap_pend_q) || $past(slip_rise);
    endproperty
    a_wrap_single: assert property (p_wrap_single) else $error("wrap flag without rollover"); // [RULE_19]
    property p_ddr_capture;
        @(posedge clk_i) disable iff (rst_i) ddr_mode && $past(ddr_mode) |-> word_q[1:0] == {$past(samp_q[0]), $past(samp_q[4])};
    endproperty
    a_ddr_capture: assert property (p_ddr_capture) else $error("double rate capture wrong"); // [RULE_22]

    c_lock:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_q));
    c_wrap:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(wrap_q));
    c_slip:  cover property (@(posedge clk_i) disable iff (rst_i) slip_rise ##[1:40] stb_q);
    c_frozen: cover property (@(posedge clk_i) disable iff (rst_i) freeze_q && pick_on && seen_edge && target != phase_q);
    c_ddr:   cover property (@(posedge clk_i) disable iff (rst_i) ddr_mode && stb_q);
endmodule : lvdsrx_top
`default_nettype wire

// ---- sim/lvdsrx_tx_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Far-end transmitter. It repeats one word MSB first and shows each bit to the eight
// sampling phases with a chosen skew: phases below the skew still see the previous bit.
module lvdsrx_tx_model (
    input  wire logic       clk_i,
    input  wire logic [9:0] pat_i,
    input  wire logic [3:0] len_i,
    input  wire logic [2:0] skew_i,
    output var  logic [7:0] ser_phase_o
);
    logic [3:0] idx_q  = 4'h0;
    logic       cur_q  = 1'b0;
    logic       prev_q = 1'b0;

    // The word repeats without end, so training length is met again after any receiver reset.
    always_ff @(posedge clk_i) begin
        idx_q  <= (idx_q + 4'h1 >= len_i) ? 4'h0 : idx_q + 4'h1;
        cur_q  <= pat_i[len_i - 4'h1 - idx_q];
        prev_q <= cur_q;
    end

    always_comb begin
        for (int k = 0; k < 8; k++) begin
            ser_phase_o[k] = (k >= int'(skew_i)) ? cur_q : prev_q;
        end
    end
endmodule : lvdsrx_tx_model
`default_nettype wire

// ---- sim/tb_lvdsrx_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_lvdsrx_top;
    import lvdsrx_pkg::*;
    logic                clk_i    = 1'b0;
    logic                rst_i    = 1'b1;
    logic                wb_cyc   = 1'b0;
    logic                wb_stb   = 1'b0;
    logic                wb_we    = 1'b0;
    logic [3:0]          wb_adr   = 4'h0;
    logic [31:0]         wb_wdat  = 32'h0000_0000;
    // The line stays idle until the reset values are read, so the picker cannot move early.
    logic [9:0]          pat      = 10'h000;
    logic [3:0]          pat_len  = 4'h4;
    logic [2:0]          skew     = 3'h2;
    logic [31:0]         wb_rdat, rd, st0;
    logic                wb_ack, rx_stb, par_clk, lock, wrap;
    logic [7:0]          ser_phase;
    logic [MAX_WORD-1:0] rx_word, w, wp;
    int                  error_cnt = 0;
    int                  checks_done = 0;
    int                  wrap_len = 0, wrap_w = 0, wrap_cnt = 0, wc0, gap;
    logic [31:0]         mode_cfg [4] = '{32'h0000_0443, 32'h0000_0444, 32'h0000_0441, 32'h0000_0442};
    logic [31:0]         mode_gap [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0004, 32'h0000_0004};

    always #2 clk_i = ~clk_i;

    lvdsrx_tx_model i_lvdsrx_tx_model (.clk_i(clk_i), .pat_i(pat), .len_i(pat_len), .skew_i(skew),
                                       .ser_phase_o(ser_phase));
    lvdsrx_top i_lvdsrx_top (.clk_i(clk_i), .rst_i(rst_i), .ser_phase_i(ser_phase), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_word_o(rx_word), .rx_word_stb_o(rx_stb),
        .par_clk_o(par_clk), .lock_o(lock), .wrap_o(wrap));

    // Width of each wrap pulse in clock cycles; only the last one is kept.
    always @(posedge clk_i) begin
        if (wrap === 1'b1) begin
            wrap_len++;
        end else if (wrap_len != 0) begin
            wrap_w = wrap_len;
            wrap_cnt++;
            wrap_len = 0;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        check("wb ack", {31'h0, wb_ack}, 32'h0000_0001);
    endtask : wb_xfer

    task automatic get_word(output logic [MAX_WORD-1:0] wo);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rx_stb !== 1'b1 && n < 40);
        wo = rx_word;
    endtask : get_word

    task automatic wait_lock(input logic want, input int lim, input string what);
        int n;
        n = 0;
        while (lock !== want && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        check(what, {31'h0, lock}, {31'h0, want});
    endtask : wait_lock

    // Cycles between two word strobes, or between two rising edges of the parallel clock.
    task automatic gap_of(input logic par, output int g);
        int n;
        int c;
        logic s;
        logic p;
        n = 0;
        c = -1;
        p = 1'b1;
        g = 0;
        while (g == 0 && n < 100) begin
            @(posedge clk_i);
            s = par ? par_clk : rx_stb;
            if (s === 1'b1 && (!par || p === 1'b0)) begin
                if (c >= 0) g = c;
                c = 0;
            end
            if (c >= 0) c++;
            p = s;
            n++;
        end
    endtask : gap_of

    // The base word is 1100, so a one-bit delay turns any received word into its right rotation.
    task automatic slip_once(input logic [MAX_WORD-1:0] b4, input int cnt, output logic [MAX_WORD-1:0] a);
        logic [MAX_WORD-1:0] b;
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0008, rd);
        repeat (2) get_word(a);
        check("slip word", {28'h0, a[3:0]}, {28'h0, b4[0], b4[3:1]});
        repeat (3) get_word(b);
        check("held slip", {28'h0, b[3:0]}, {28'h0, a[3:0]});
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
        repeat (2) get_word(b);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check("slip count", {28'h0, rd[11:8]}, 32'(cnt));
    endtask : slip_once

    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, ADDR_CFG, 32'h0000_0000, rd);
        check("cfg reset", rd, 32'h0000_0AA0);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check("status reset", rd, 32'h0000_0000);
        wb_xfer(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b0, 4'h2, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        wb_xfer(1'b1, ADDR_CFG, 32'h0000_0440, rd);
        wb_xfer(1'b0, ADDR_CFG, 32'h0000_0000, rd);
        check("cfg", rd, 32'h0000_0440);
        pat <= 10'h00C;
        wait_lock(1'b1, 1000, "lock");
        gap_of(1'b0, gap);
        check("word gap", 32'(gap), 32'h0000_0004);
        repeat (3) get_word(w);
        check("word", 32'(w[3:0] inside {4'hC, 4'h6, 4'h3, 4'h9}), 32'h0000_0001);
        wc0 = wrap_cnt;
        for (int i = 1; i <= 4; i++) begin
            slip_once(w, i % 4, w);
        end
        check("wrap pulses", 32'(wrap_cnt - wc0), 32'h0000_0001);
        check("wrap width", 32'(wrap_w), 32'h0000_0004);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0004, rd);
        repeat (4) get_word(wp);
        check("fifo reset word", 32'(wp[3:0] inside {4'hC, 4'h6, 4'h3, 4'h9}), 32'h0000_0001);
        check("fifo reset lock", {31'h0, lock}, 32'h0000_0001);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st0);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0001, rd);
        skew <= 3'h6;
        repeat (400) @(posedge clk_i);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check("frozen phase", {29'h0, rd[3:1]}, {29'h0, st0[3:1]});
        check("frozen lock", {31'h0, lock}, 32'h0000_0001);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
        wait_lock(1'b0, 300, "lock drop");
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0004, rd);
        check("unlocked fifo reset", {31'h0, lock}, 32'h0000_0000);
        wait_lock(1'b1, 1000, "relock");
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0002, rd);
        wait_lock(1'b0, 20, "reset lock");
        wait_lock(1'b1, 1000, "retrain");
        for (int m = 0; m < 4; m++) begin
            wb_xfer(1'b1, ADDR_CFG, mode_cfg[m], rd);
            repeat (20) @(posedge clk_i);
            gap_of(m == 2, gap);
            check("mode gap", 32'(gap), mode_gap[m]);
        end
        wb_xfer(1'b1, ADDR_CFG, 32'h0000_044A, rd);
        repeat (20) get_word(w);
        check("falling edge word", 32'(w[3:0] inside {4'hC, 4'h6, 4'h3, 4'h9}), 32'h0000_0001);
        wb_xfer(1'b1, ADDR_CFG, 32'h0000_0443, rd);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st0);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0008, rd);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check("bypass slip", {28'h0, rd[11:8]}, {28'h0, st0[11:8]});
        close_out();
    end
endmodule : tb_lvdsrx_top
`default_nettype wire
